// [common/fcc_cfg.svh]
// register offsets, field positions, reset values and counts of the feac block
`ifndef FCC_CFG_SVH
`define FCC_CFG_SVH

`define FCC_ADDR_W          3
`define FCC_DATA_W          8

`define FCC_ADDR_TX_CTRL    3'h0
`define FCC_ADDR_TX_CODE_A  3'h1
`define FCC_ADDR_TX_CODE_B  3'h2
`define FCC_ADDR_STATUS     3'h3
`define FCC_ADDR_RX_FIFO    3'h4

`define FCC_STAT_EMPTY      0
`define FCC_STAT_DETECT     1
`define FCC_STAT_IDLE       2
`define FCC_STAT_OVERFLOW   3
`define FCC_STAT_TX_BUSY    4

`define FCC_RST_MODE        2'h0
`define FCC_RST_CODE        6'h00

`define FCC_TX_LAST_BIT     4'hf
`define FCC_TX_LAST_REP     4'h9
`define FCC_ONES_WORD       16'hffff
`define FCC_RX_CONFIRM_PRE  2'h2
`define FCC_RX_CONFIRM_MAX  2'h3
`define FCC_RX_DIFF_PRE     1'h1
`define FCC_RX_GAP_LAST     4'hf
`define FCC_RX_IDLE_PRE     4'hf

`endif

// [common/fcc_pkg.sv]
// types shared by the feac codeword controller
package fcc_pkg;
    `include "fcc_cfg.svh"

    typedef logic [`FCC_ADDR_W-1:0] fcc_addr_t;
    typedef logic [`FCC_DATA_W-1:0] fcc_data_t;
    typedef logic [5:0]             fcc_code_t;

    typedef enum logic [1:0] {
        FCC_MODE_IDLE,
        FCC_MODE_SINGLE,
        FCC_MODE_DUAL,
        FCC_MODE_CONT
    } fcc_mode_t;

    typedef enum logic [2:0] {
        FCC_TX_ONES,
        FCC_TX_SINGLE_A,
        FCC_TX_DUAL_A,
        FCC_TX_DUAL_B,
        FCC_TX_CONT
    } fcc_tx_state_t;
endpackage

// [rtl/fcc_sync.sv]
// two flip-flop synchroniser for a single pin level
`timescale 1ns/100ps
module fcc_sync (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            meta_r   <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// [rtl/fcc_top.sv]
// feac codeword controller: transmit codeword generator, receive detector, fifo
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/100ps
`include "fcc_cfg.svh"
module fcc_top
    import fcc_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          srst,
    input  wire fcc_pkg::fcc_addr_t addr,
    input  wire fcc_pkg::fcc_data_t wr_data,
    input  wire logic          wr_en,
    input  wire logic          rd_en,
    output fcc_pkg::fcc_data_t rd_data,
    input  wire logic          line_clk,
    input  wire logic          rx_feac_data,
    output logic               tx_feac_data
);
    import fcc_pkg::*;

    // ---------------- pin sampling
    logic          line_clk_s;
    logic          line_clk_d_r;
    logic          rx_bit_s;
    logic          line_rise;

    fcc_sync u_sync_clk (
        .clk      (clk),
        .srst     (srst),
        .async_in (line_clk),
        .sync_out (line_clk_s)
    );

    fcc_sync u_sync_rx (
        .clk      (clk),
        .srst     (srst),
        .async_in (rx_feac_data),
        .sync_out (rx_bit_s)
    );

    always_ff @(posedge clk) begin
        if (srst)
            line_clk_d_r <= 1'b0;
        else
            line_clk_d_r <= line_clk_s;
    end

    assign line_rise = line_clk_s & ~line_clk_d_r;

    // ---------------- register decode
    logic          wr_ctrl;
    logic          wr_code_a;
    logic          wr_code_b;
    logic          wr_status;
    logic          rd_fifo;

    assign wr_ctrl   = wr_en & (addr == `FCC_ADDR_TX_CTRL);
    assign wr_code_a = wr_en & (addr == `FCC_ADDR_TX_CODE_A);
    assign wr_code_b = wr_en & (addr == `FCC_ADDR_TX_CODE_B);
    assign wr_status = wr_en & (addr == `FCC_ADDR_STATUS);
    assign rd_fifo   = rd_en & (addr == `FCC_ADDR_RX_FIFO);

    fcc_mode_t     mode_r;
    fcc_code_t     code_a_r;
    fcc_code_t     code_b_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            mode_r   <= fcc_mode_t'(`FCC_RST_MODE);
            code_a_r <= `FCC_RST_CODE;
            code_b_r <= `FCC_RST_CODE;
        end else begin
            if (wr_ctrl)
                mode_r <= fcc_mode_t'(wr_data[1:0]);
            if (wr_code_a)
                code_a_r <= wr_data[5:0];
            if (wr_code_b)
                code_b_r <= wr_data[5:0];
        end
    end

    // ---------------- transmit codeword generator
    fcc_tx_state_t tx_state_r;
    fcc_tx_state_t tx_state_nxt;
    logic [3:0]    tx_rep_r;
    logic [3:0]    tx_rep_nxt;
    logic [3:0]    tx_bit_r;
    logic [15:0]   tx_shift_r;
    logic [15:0]   tx_word_nxt;
    logic          tx_pend_r;
    logic          tx_boundary;
    fcc_code_t     tx_code_sel;
    logic          tx_busy;

    assign tx_boundary = line_rise & (tx_bit_r == `FCC_TX_LAST_BIT);
    assign tx_busy     = (tx_state_r != FCC_TX_ONES) | tx_pend_r;

    // new mode only taken when a codeword ends
    always_comb begin
        tx_state_nxt = tx_state_r;
        tx_rep_nxt   = tx_rep_r;
        if (tx_pend_r) begin
            tx_rep_nxt = 4'h0;
            case (mode_r)
                FCC_MODE_IDLE:   tx_state_nxt = FCC_TX_ONES;
                FCC_MODE_SINGLE: tx_state_nxt = FCC_TX_SINGLE_A;
                FCC_MODE_DUAL:   tx_state_nxt = FCC_TX_DUAL_A;
                FCC_MODE_CONT:   tx_state_nxt = FCC_TX_CONT;
                default:         tx_state_nxt = FCC_TX_ONES;
            endcase
        end else begin
            case (tx_state_r)
                FCC_TX_SINGLE_A: begin
                    if (tx_rep_r == `FCC_TX_LAST_REP)
                        tx_state_nxt = FCC_TX_ONES;
                    else
                        tx_rep_nxt = tx_rep_r + 4'h1;
                end
                FCC_TX_DUAL_A: begin
                    if (tx_rep_r == `FCC_TX_LAST_REP) begin
                        tx_state_nxt = FCC_TX_DUAL_B;
                        tx_rep_nxt   = 4'h0;
                    end else begin
                        tx_rep_nxt = tx_rep_r + 4'h1;
                    end
                end
                FCC_TX_DUAL_B: begin
                    if (tx_rep_r == `FCC_TX_LAST_REP)
                        tx_state_nxt = FCC_TX_ONES;
                    else
                        tx_rep_nxt = tx_rep_r + 4'h1;
                end
                default: begin
                    tx_state_nxt = tx_state_r;
                end
            endcase
        end
    end

    assign tx_code_sel = (tx_state_nxt == FCC_TX_DUAL_B) ? code_b_r
                                                          : code_a_r;

    // zero, c1..c6, zero, eight ones; msb of the word goes first
    assign tx_word_nxt = (tx_state_nxt == FCC_TX_ONES) ? `FCC_ONES_WORD
                       : {1'b0, tx_code_sel[0], tx_code_sel[1],
                          tx_code_sel[2], tx_code_sel[3], tx_code_sel[4],
                          tx_code_sel[5], 1'b0, 8'hff};

    always_ff @(posedge clk) begin
        if (srst)
            tx_pend_r <= 1'b0;
        else
            tx_pend_r <= wr_ctrl | (tx_pend_r & ~tx_boundary);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            tx_state_r <= FCC_TX_ONES;
            tx_rep_r   <= 4'h0;
        end else if (tx_boundary) begin
            tx_state_r <= tx_state_nxt;
            tx_rep_r   <= tx_rep_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            tx_bit_r     <= 4'h0;
            tx_shift_r   <= `FCC_ONES_WORD;
            tx_feac_data <= 1'b1;
        end else if (line_rise) begin
            tx_bit_r     <= tx_bit_r + 4'h1;
            tx_feac_data <= tx_shift_r[15];
            if (tx_boundary)
                tx_shift_r <= tx_word_nxt;
            else
                tx_shift_r <= {tx_shift_r[14:0], 1'b1};
        end
    end

    // ---------------- receive codeword detector (no tx state used)
    logic [15:0]   rx_win_r;
    logic          rx_new_r;
    logic          cw_hit;
    logic          rx_eval;
    fcc_code_t     rx_code;
    fcc_code_t     cand_r;
    logic [1:0]    cand_cnt_r;
    logic          cand_same;
    logic [3:0]    gap_r;
    logic          gap_lost;
    fcc_code_t     cur_r;
    logic          det_r;
    logic          diff_r;
    logic          rx_differs;
    logic          diff_clear;
    logic          confirm;
    logic [3:0]    ones_r;
    logic          idle_r;
    logic          idle_set;

    always_ff @(posedge clk) begin
        if (srst) begin
            rx_win_r <= `FCC_ONES_WORD;
            rx_new_r <= 1'b0;
        end else begin
            rx_new_r <= line_rise;
            if (line_rise)
                rx_win_r <= {rx_win_r[14:0], rx_bit_s};
        end
    end

    // pattern checked after every new bit, so any alignment is found
    assign cw_hit  = ~rx_win_r[15] & ~rx_win_r[8]
                   & (rx_win_r[7:0] == 8'hff);
    assign rx_eval = rx_new_r & cw_hit;
    assign rx_code = {rx_win_r[9], rx_win_r[10], rx_win_r[11],
                      rx_win_r[12], rx_win_r[13], rx_win_r[14]};

    assign cand_same  = (rx_code == cand_r);
    assign gap_lost   = rx_new_r & ~cw_hit & (gap_r == `FCC_RX_GAP_LAST);
    assign confirm    = rx_eval & cand_same
                      & (cand_cnt_r == `FCC_RX_CONFIRM_PRE);
    assign rx_differs = rx_eval & det_r & (rx_code != cur_r);
    assign diff_clear = rx_differs & (diff_r == `FCC_RX_DIFF_PRE);
    assign idle_set   = rx_new_r & rx_win_r[0]
                      & (ones_r == `FCC_RX_IDLE_PRE);

    // missing codeword at the expected place breaks the run
    always_ff @(posedge clk) begin
        if (srst) begin
            cand_r     <= `FCC_RST_CODE;
            cand_cnt_r <= 2'h0;
            gap_r      <= 4'h0;
        end else if (rx_eval) begin
            gap_r  <= 4'h0;
            cand_r <= rx_code;
            if (!cand_same)
                cand_cnt_r <= 2'h1;
            else if (cand_cnt_r != `FCC_RX_CONFIRM_MAX)
                cand_cnt_r <= cand_cnt_r + 2'h1;
        end else if (rx_new_r) begin
            gap_r <= gap_r + 4'h1;
            if (gap_lost)
                cand_cnt_r <= 2'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            det_r  <= 1'b0;
            cur_r  <= `FCC_RST_CODE;
            diff_r <= 1'b0;
        end else begin
            if (confirm) begin
                det_r  <= 1'b1;
                cur_r  <= rx_code;
                diff_r <= 1'b0;
            end else if (diff_clear | idle_set) begin
                det_r  <= 1'b0;
                diff_r <= 1'b0;
            end else if (rx_differs) begin
                diff_r <= 1'b1;
            end else if (rx_eval) begin
                diff_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ones_r <= 4'h0;
            idle_r <= 1'b0;
        end else begin
            if (rx_new_r) begin
                if (!rx_win_r[0])
                    ones_r <= 4'h0;
                else if (ones_r != `FCC_RX_IDLE_PRE)
                    ones_r <= ones_r + 4'h1;
            end
            if (confirm)
                idle_r <= 1'b0;
            else if (idle_set)
                idle_r <= 1'b1;
        end
    end

    // ---------------- receive fifo, one code per entry
    // both ends live on clk, so neither depends on line_clk running
    fcc_code_t     fifo_mem_r [4];
    logic [2:0]    wr_ptr_r;
    logic [2:0]    rd_ptr_r;
    logic          fifo_empty;
    logic          fifo_full;
    logic          fifo_push;
    logic          fifo_pop;
    logic          fifo_drop;
    logic          ovf_r;
    logic          ovf_clr;

    assign fifo_empty = (wr_ptr_r == rd_ptr_r);
    assign fifo_full  = (wr_ptr_r[2] != rd_ptr_r[2])
                      & (wr_ptr_r[1:0] == rd_ptr_r[1:0]);
    assign fifo_push  = confirm & ~fifo_full;
    assign fifo_drop  = confirm & fifo_full;
    assign fifo_pop   = rd_fifo & ~fifo_empty;
    assign ovf_clr    = wr_status & wr_data[`FCC_STAT_OVERFLOW];

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ptr_r <= 3'h0;
            rd_ptr_r <= 3'h0;
        end else begin
            if (fifo_push)
                wr_ptr_r <= wr_ptr_r + 3'h1;
            if (fifo_pop)
                rd_ptr_r <= rd_ptr_r + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (fifo_push)
            fifo_mem_r[wr_ptr_r[1:0]] <= rx_code;
    end

    // a new overflow beats a clear in the same cycle
    always_ff @(posedge clk) begin
        if (srst)
            ovf_r <= 1'b0;
        else
            ovf_r <= fifo_drop | (ovf_r & ~ovf_clr);
    end

    // ---------------- read data, one cycle after the strobe
    fcc_data_t     status_word;
    fcc_data_t     rd_mux;

    assign status_word = {3'h0, tx_busy, ovf_r, idle_r, det_r,
                          fifo_empty};

    assign rd_mux =
        (addr == `FCC_ADDR_TX_CTRL)   ? {6'h00, mode_r} :
        (addr == `FCC_ADDR_TX_CODE_A) ? {2'h0, code_a_r} :
        (addr == `FCC_ADDR_TX_CODE_B) ? {2'h0, code_b_r} :
        (addr == `FCC_ADDR_STATUS)    ? status_word :
        (addr == `FCC_ADDR_RX_FIFO && !fifo_empty)
                                      ? {2'h0, fifo_mem_r[rd_ptr_r[1:0]]}
                                      : 8'h00;

    always_ff @(posedge clk) begin
        if (srst)
            rd_data <= 8'h00;
        else if (rd_en)
            rd_data <= rd_mux;
        else
            rd_data <= 8'h00;
    end
endmodule

// [bench/fcc_top_monitor.sv]
// port checker for the feac codeword controller
`timescale 1ns/100ps
module fcc_top_monitor (
    input wire logic               clk,
    input wire logic               srst,
    input wire fcc_pkg::fcc_addr_t addr,
    input wire fcc_pkg::fcc_data_t wr_data,
    input wire logic               wr_en,
    input wire logic               rd_en,
    input wire fcc_pkg::fcc_data_t rd_data,
    input wire logic               line_clk,
    input wire logic               rx_feac_data,
    input wire logic               tx_feac_data
);
    import fcc_pkg::*;
    logic       line_q_r;
    logic [3:0] since_rise_r;
    logic       tx_on_r;
    // cycles since the raw line clock last rose
    always_ff @(posedge clk) begin
        line_q_r <= line_clk;
        if (line_clk && !line_q_r) since_rise_r <= 4'h0;
        else if (since_rise_r != 4'hf) since_rise_r <= since_rise_r + 4'h1;
    end
    always_ff @(posedge clk) begin
        if (srst) tx_on_r <= 1'b0;
        else if (wr_en && addr == 3'h0 && wr_data[1:0] != 2'h0)
            tx_on_r <= 1'b1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_code_wr;
        wr_en && (addr inside {3'h1, 3'h2});
    endsequence
    sequence s_code_rd;
        rd_en && addr == $past(addr, 2);
    endsequence
    a_read_idle_zero: assert property (!$past(rd_en) |-> rd_data == 8'h00)
        else $error("rd_data not zero without a read");
    a_unmapped_read: assert property ($past(rd_en) && $past(addr) > 3'h4
        |-> rd_data == 8'h00) else $error("unmapped read not zero");
    a_code_width_only: assert property ($past(rd_en) &&
        ($past(addr) inside {3'h1, 3'h2, 3'h4}) |-> rd_data[7:6] == 2'h0)
        else $error("code read wider than six bits");
    a_ctrl_width_only: assert property ($past(rd_en) && $past(addr) == 3'h0
        |-> rd_data[7:2] == 6'h00) else $error("mode read wider than two bits");
    a_code_readback: assert property (s_code_wr ##2 s_code_rd
        |=> rd_data[5:0] == $past(wr_data[5:0], 3))
        else $error("code readback differs from write");
    a_idle_detect_excl: assert property ($past(rd_en) &&
        $past(addr) == 3'h3 |-> !(rd_data[1] && rd_data[2]))
        else $error("idle and detect both set");
    a_tx_ones_idle: assert property (!tx_on_r |-> tx_feac_data)
        else $error("tx not ones before any mode");
    a_tx_line_aligned: assert property ($changed(tx_feac_data)
        |-> since_rise_r <= 4'h8) else $error("tx moved off a line edge");
endmodule
bind fcc_top fcc_top_monitor u_mon (.clk(clk), .srst(srst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .line_clk(line_clk), .rx_feac_data(rx_feac_data),
    .tx_feac_data(tx_feac_data));

// [bench/fcc_line_model.sv]
// far end of the feac bit stream: line clock, rx words, tx capture
`timescale 1ns/100ps
module fcc_line_model (
    output logic              line_clk,
    output logic              rx_feac_data,
    input wire logic          tx_feac_data,
    input wire fcc_pkg::fcc_code_t rx_code,
    input wire logic          rx_on,
    output logic [15:0]       tx_word,
    output int                rx_sent
);
    import fcc_pkg::*;
    logic [3:0]  idx_r = 4'h0;
    logic [15:0] cur_r = 16'hffff;
    function automatic logic [15:0] codeword(input fcc_code_t c);
        return {1'b0, c[0], c[1], c[2], c[3], c[4], c[5], 1'b0,
                8'hff};
    endfunction
    initial begin
        line_clk = 1'b0;
        rx_feac_data = 1'b1;
        tx_word = 16'hffff;
        rx_sent = 0;
        #13;
        forever #40 line_clk = ~line_clk;
    end
    // new word chosen only at a boundary, so words are never cut
    always @(negedge line_clk) begin
        if (idx_r == 4'h0) cur_r = rx_on ? codeword(rx_code) : 16'hffff;
        rx_feac_data <= cur_r[4'hf - idx_r];
        if (idx_r == 4'hf) rx_sent <= rx_sent + 1;
        idx_r <= idx_r + 4'h1;
        tx_word <= {tx_word[14:0], tx_feac_data};
    end
endmodule

// [bench/tb_fcc_top.sv]
// self-checking bench for the feac codeword controller
`timescale 1ns/100ps
module tb_fcc_top;
    import fcc_pkg::*;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    fcc_addr_t   addr = 3'h0;
    fcc_data_t   wr_data = 8'h00;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    fcc_data_t   rd_data;
    logic        line_clk;
    logic        rx_feac_data;
    logic        tx_feac_data;
    fcc_code_t   rx_code = 6'h00;
    logic        rx_on = 1'b0;
    logic [15:0] tx_word;
    logic [15:0] exp_a = 16'h0000;
    logic [15:0] exp_b = 16'h0000;
    int          rx_sent;
    int          n_fail = 0;
    int          compares = 0;
    int          cycles = 0;
    int          n_a = 0;
    int          n_b = 0;
    fcc_code_t   ovf_seq [5] = '{6'h21, 6'h0e, 6'h21, 6'h0e, 6'h21};

    always #2.5 clk = ~clk;

    fcc_top u_dut (.clk(clk), .srst(srst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .line_clk(line_clk), .rx_feac_data(rx_feac_data),
        .tx_feac_data(tx_feac_data));
    fcc_line_model u_line (.line_clk(line_clk), .rx_feac_data(rx_feac_data),
        .tx_feac_data(tx_feac_data), .rx_code(rx_code), .rx_on(rx_on),
        .tx_word(tx_word), .rx_sent(rx_sent));

    always @(posedge line_clk) begin
        if (tx_word === exp_a) n_a++;
        if (tx_word === exp_b) n_b++;
    end

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic wr(input fcc_addr_t a, input fcc_data_t d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic chk_reg(input string nm, input fcc_data_t e,
                           input fcc_data_t g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_num(input string nm, input int e, input int g);
        compares++;
        if (g != e) begin
            n_fail++;
            $display("ERROR %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    // read and compare in one bus cycle
    task automatic rd(input fcc_addr_t a, input fcc_data_t e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk_reg($sformatf("reg %0d", a), e, rd_data);
    endtask

    task automatic line_words(input int n);
        repeat (n * 16) @(posedge line_clk);
    endtask

    task automatic run_mode(input fcc_mode_t m, input int words);
        n_a = 0;
        n_b = 0;
        wr(3'h0, {6'h00, m});
        line_words(words);
    endtask

    // words are counted from a boundary, the code changes only there
    task automatic send(input fcc_code_t c, input logic on, input int n);
        int s;
        @(rx_sent);
        s = rx_sent;
        rx_code <= c;
        rx_on <= on;
        while (rx_sent < s + n) @(posedge clk);
        repeat (20) @(posedge clk);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd(3'h0, 8'h00);
        rd(3'h1, 8'h00);
        rd(3'h2, 8'h00);
        rd(3'h3, 8'h01);
        wr(3'h6, 8'hff);
        for (int a = 5; a < 8; a++) rd(a[2:0], 8'h00);
        rd(3'h4, 8'h00);
        rd(3'h3, 8'h01);
        wr(3'h1, 8'hd5);
        rd(3'h1, 8'h15);
        wr(3'h2, 8'h6c);
        rd(3'h2, 8'h2c);
        exp_a = u_line.codeword(6'h15);
        exp_b = u_line.codeword(6'h2c);
        run_mode(FCC_MODE_SINGLE, 14);
        chk_num("single a", 10, n_a);
        chk_num("single b", 0, n_b);
        run_mode(FCC_MODE_DUAL, 24);
        chk_num("dual a", 10, n_a);
        chk_num("dual b", 10, n_b);
        run_mode(FCC_MODE_CONT, 22);
        chk_num("cont a", 1, int'(n_a >= 19));
        run_mode(FCC_MODE_IDLE, 3);
        n_a = 0;
        line_words(6);
        chk_num("idle a", 0, n_a);
        chk_num("idle word", 1, int'(tx_word === 16'hffff));
        send(6'h00, 1'b0, 1);
        send(6'h0b, 1'b1, 3);
        rd(3'h3, 8'h02);
        rd(3'h4, 8'h0b);
        rd(3'h3, 8'h03);
        rd(3'h4, 8'h00);
        send(6'h00, 1'b0, 2);
        rd(3'h3, 8'h05);
        foreach (ovf_seq[i]) send(ovf_seq[i], 1'b1, 3);
        rd(3'h3, 8'h0a);
        for (int i = 0; i < 4; i++) rd(3'h4, {2'h0, ovf_seq[i]});
        rd(3'h3, 8'h0b);
        wr(3'h3, 8'h08);
        rd(3'h3, 8'h03);
        send(6'h33, 1'b1, 2);
        rd(3'h3, 8'h01);
        send(6'h00, 1'b0, 2);
        rd(3'h3, 8'h04);
        rd(3'h4, 8'h33);
        rd(3'h3, 8'h05);
        print_verdict();
    end
endmodule
